// ==== tic_pkg.sv ====
// Package of register map, field positions and codes for the timer I/O block.
//
// Function
// - Low-start output: low, high or toggle on match
// - High-start output: low, high or toggle on match
// - Codes 0000/0100 hold pin; reset drives zero
// - Ch3/4 capture on rise, fall or both
// - Buffered C register holds its pin level and never captures; only its driver enable follows the code
// - Ch5 code 00000 is compare; others prohibited
// - Ch5 10001/10010/10011 capture rise, fall, both
// - Ch5 11001/11010/11011 measure low pulse width
// - Ch5 11101/11110/11111 measure high pulse width
// - Clear enables zero ch5 counters on events
// - Clear register bits 7..3 read zero
// - Enable bit 7 gates A-event converter start
// - Bit 6 gates ch4 trough converter start
// - Bit 5 gates underflow interrupt, ch1/2 only
// - Bit 4 gates overflow interrupt
// - Bit 3 gates D interrupt, ch0/3/4 only
// - Bit 2 gates C interrupt, ch0/3/4 only
// - Bit 1 gates B interrupt
// - Bit 0 gates A interrupt
// - Flags clear by zero write after one read
package tic_pkg;

	// ==========================================================
	// Register byte offsets.
	localparam logic [7:0] OFS_CH3_IO_HIGH = 8'h00;
	localparam logic [7:0] OFS_CH3_IO_LOW  = 8'h04;
	localparam logic [7:0] OFS_CH4_IO_HIGH = 8'h08;
	localparam logic [7:0] OFS_CH4_IO_LOW  = 8'h0C;
	localparam logic [7:0] OFS_CH5U_IO     = 8'h10;
	localparam logic [7:0] OFS_CH5V_IO     = 8'h14;
	localparam logic [7:0] OFS_CH5W_IO     = 8'h18;
	localparam logic [7:0] OFS_CLEAR_EN    = 8'h1C;
	localparam logic [7:0] OFS_IRQ_EN      = 8'h20;
	localparam logic [7:0] OFS_STATUS      = 8'h24;
	localparam logic [7:0] OFS_MODE        = 8'h28;

	// ==========================================================
	// Field positions and widths.
	localparam int IO4_W        = 4;
	localparam int IO5_W        = 5;
	localparam int CLR_W        = 3;
	localparam int FLAG_W       = 6;
	localparam int BIT_ADC_TRIG = 7;
	localparam int BIT_TROUGH   = 6;
	localparam int BIT_UNDER    = 5;
	localparam int BIT_OVER     = 4;
	localparam int BIT_D        = 3;
	localparam int BIT_C        = 2;
	localparam int BIT_B        = 1;
	localparam int BIT_A        = 0;

	// ==========================================================
	// Reset values.
	localparam logic [7:0] RST_REG = 8'h00;

	// ==========================================================
	// Timing counts.
	// Edges after reset before the pin synchronisers hold real samples.
	localparam logic [1:0] SYNC_WARM = 2'h3;

	// ==========================================================
	// Channel 5 I/O codes.
	localparam logic [4:0] C5_COMPARE = 5'h00;
	localparam logic [4:0] C5_RISE    = 5'h11;
	localparam logic [4:0] C5_FALL    = 5'h12;
	localparam logic [4:0] C5_BOTH    = 5'h13;
	localparam logic [2:0] C5_LOWPW   = 3'h6;
	localparam logic [2:0] C5_HIGHPW  = 3'h7;

	// Operating mode decoded from a channel 5 code.
	typedef enum logic [2:0] {
		C5M_OFF,
		C5M_COMPARE,
		C5M_CAPTURE,
		C5M_LOW_WIDTH,
		C5M_HIGH_WIDTH
	} tic_c5mode_t;

endpackage

// ==== tic_timer_io_ctrl.sv ====
// Pin I/O control, channel 5 clear enables and interrupt enables of a timer.
//
// The placing of the registers and register access over APB were decided locally.
module tic_timer_io_ctrl #(
	parameter int IRQ_CHANNEL = 4
) (
	input  wire logic                      I_REF_CLK,
	input  wire logic                      I_RESETN,
	input  wire logic                      PSEL,
	input  wire logic                      PENABLE,
	input  wire logic                      PWRITE,
	input  wire logic [7:0]                PADDR,
	input  wire logic [31:0]               PWDATA,
	output logic      [31:0]               PRDATA,
	output logic                           PREADY,
	output logic                           PSLVERR,
	input  wire logic [3:0]                I_CMP_MATCH,
	input  wire logic [3:0]                I_PIN_IN,
	output logic      [3:0]                O_PIN_OUT,
	output logic      [3:0]                O_PIN_OE,
	output logic      [3:0]                O_CAPTURE,
	input  wire logic [2:0]                I_CH5_MATCH,
	input  wire logic [2:0]                I_CH5_PIN,
	input  wire logic [2:0]                I_CH5_TROUGH,
	input  wire logic [2:0]                I_CH5_CREST,
	output logic      [2:0]                O_CH5_CAPTURE,
	output logic      [2:0]                O_CH5_COUNT_EN,
	output logic      [2:0]                O_CH5_CLEAR,
	input  wire logic [tic_pkg::FLAG_W-1:0] I_FLAG_SET,
	input  wire logic                      I_TROUGH_UNDERFLOW,
	output logic      [tic_pkg::FLAG_W-1:0] O_IRQ,
	output logic                           O_ADC_START
);
	import tic_pkg::*;

	// ==========================================================
	// Declarations.
	logic [IO4_W-1:0]  io4_q [4];
	logic [IO5_W-1:0]  io5_q [3];
	logic [CLR_W-1:0]  clr_en_q;
	logic [7:0]        irq_en_q;
	logic [FLAG_W-1:0] flag_q;
	logic [FLAG_W-1:0] seen_one_q;
	logic [1:0]        buf_a_en_q;
	logic [3:0]        pin_s1_q;
	logic [3:0]        pin_s2_q;
	logic [3:0]        pin_s3_q;
	logic [2:0]        c5_s1_q;
	logic [2:0]        c5_s2_q;
	logic [2:0]        c5_s3_q;
	logic [3:0]        pin_out_q;
	logic [3:0]        capture_q;
	logic [2:0]        c5_capture_q;
	logic [2:0]        c5_clear_q;
	logic [2:0]        c5_count_en_q;
	logic [3:0]        io4_ignored;
	logic              access;
	logic              wr;
	logic              rd;
	logic              mapped;
	logic [7:0]        irq_mask;
	logic [7:0]        rd_byte;
	logic [1:0]        warm_cnt_q;
	logic              sync_ready;

	// Writable bits of the enable register depend on the channel built.
	// Bits outside the mask are reserved: they read zero and a flag
	// behind a reserved enable never sets, so no request can leak out.
	function automatic logic [7:0] enable_mask(input int ch);
		logic [7:0] m;
		m = 8'h93;
		if (ch == 4) begin
			m[BIT_TROUGH] = 1'b1;
		end
		if (ch == 1 || ch == 2) begin
			m[BIT_UNDER] = 1'b1;
		end else begin
			m[BIT_D] = 1'b1;
			m[BIT_C] = 1'b1;
		end
		return m;
	endfunction

	// Decodes a channel 5 code; prohibited codes fall to the off mode.
	// They are decoded rather than trusted: a unit set to one of them
	// neither captures, compares nor clears its counter.
	function automatic tic_c5mode_t c5_mode(input logic [IO5_W-1:0] code);
		tic_c5mode_t m;
		m = C5M_OFF;
		if (code == C5_COMPARE) begin
			m = C5M_COMPARE;
		end else if (code == C5_RISE || code == C5_FALL
			|| code == C5_BOTH) begin
			m = C5M_CAPTURE;
		end else if (code[4:2] == C5_LOWPW && code[1:0] != 2'h0) begin
			m = C5M_LOW_WIDTH;
		end else if (code[4:2] == C5_HIGHPW && code[1:0] != 2'h0) begin
			m = C5M_HIGH_WIDTH;
		end
		return m;
	endfunction

	// Edge selection shared by both capture decoders: 0 rise, 1 fall,
	// 2 or 3 both.
	function automatic logic edge_hit(input logic [1:0] sel,
		input logic now, input logic prev);
		logic r;
		r = 1'b0;
		case (sel)
			2'h0: r = now & ~prev;
			2'h1: r = ~now & prev;
			default: r = now ^ prev;
		endcase
		return r;
	endfunction

	// ==========================================================
	// APB slave: zero wait states, unmapped addresses answer with an
	// error and read zero. Every register is a single byte in the low
	// lane of its word; the upper lanes are dropped on writes, so
	// software may write whole words without side effects.
	assign access = PSEL & PENABLE;
	assign wr = access & PWRITE & mapped;
	assign rd = access & ~PWRITE & mapped;
	assign irq_mask = enable_mask(IRQ_CHANNEL);
	assign PREADY = 1'b1;

	// Address decode and read multiplexer.
	// Misaligned addresses fall to the default and are refused.
	always_comb begin
		mapped = 1'b1;
		rd_byte = 8'h00;
		case (PADDR)
			OFS_CH3_IO_HIGH: rd_byte = {4'h0, io4_q[0]};
			OFS_CH3_IO_LOW:  rd_byte = {4'h0, io4_q[1]};
			OFS_CH4_IO_HIGH: rd_byte = {4'h0, io4_q[2]};
			OFS_CH4_IO_LOW:  rd_byte = {4'h0, io4_q[3]};
			OFS_CH5U_IO:     rd_byte = {3'h0, io5_q[0]};
			OFS_CH5V_IO:     rd_byte = {3'h0, io5_q[1]};
			OFS_CH5W_IO:     rd_byte = {3'h0, io5_q[2]};
			OFS_CLEAR_EN:    rd_byte = {5'h00, clr_en_q};
			OFS_IRQ_EN:      rd_byte = irq_en_q;
			OFS_STATUS:      rd_byte = {2'h0, flag_q};
			OFS_MODE:        rd_byte = {6'h00, buf_a_en_q};
			default: mapped = 1'b0;
		endcase
	end

	assign PRDATA = {24'h000000, rd_byte};
	assign PSLVERR = access & ~mapped;

	// ==========================================================
	// Control registers, all cleared by reset. The clear enable keeps only
	// its three live bits, so the reserved upper bits read zero whatever
	// software wrote there.
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			for (int i = 0; i < 4; i++) begin
				io4_q[i] <= 4'h0;
			end
			for (int i = 0; i < 3; i++) begin
				io5_q[i] <= 5'h00;
			end
			clr_en_q <= 3'h0;
			irq_en_q <= RST_REG;
			buf_a_en_q <= 2'h0;
		end else if (wr) begin
			for (int i = 0; i < 4; i++) begin
				if (PADDR == OFS_CH3_IO_HIGH + 8'(4 * i)) begin
					io4_q[i] <= PWDATA[IO4_W-1:0];
				end
			end
			for (int i = 0; i < 3; i++) begin
				if (PADDR == OFS_CH5U_IO + 8'(4 * i)) begin
					io5_q[i] <= PWDATA[IO5_W-1:0];
				end
			end
			if (PADDR == OFS_CLEAR_EN) begin
				clr_en_q <= PWDATA[CLR_W-1:0];
			end
			if (PADDR == OFS_IRQ_EN) begin
				// Reserved enables stay zero whatever is written.
				irq_en_q <= PWDATA[7:0] & irq_mask;
			end
			if (PADDR == OFS_MODE) begin
				buf_a_en_q <= PWDATA[1:0];
			end
		end
	end

	// ==========================================================
	// Status flags. A zero write clears only a flag that was read as one
	// earlier; a one write leaves it. A set arriving with the clear wins.
	// The arming bit stops a blind zero write from losing an event that
	// software has not yet seen; any zero write drops it, so a stale
	// read cannot clear a later event.
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			flag_q <= 6'h00;
			seen_one_q <= 6'h00;
		end else begin
			for (int i = 0; i < FLAG_W; i++) begin
				if (I_FLAG_SET[i] && irq_mask[i]) begin
					flag_q[i] <= 1'b1;
				end else if (wr && PADDR == OFS_STATUS && !PWDATA[i]
					&& seen_one_q[i]) begin
					flag_q[i] <= 1'b0;
				end
				if (rd && PADDR == OFS_STATUS) begin
					seen_one_q[i] <= flag_q[i];
				end else if (wr && PADDR == OFS_STATUS && !PWDATA[i]) begin
					seen_one_q[i] <= 1'b0;
				end
			end
		end
	end

	// Interrupt requests are levels: flag and enable together.
	// They stay up until software clears the flag or drops the enable.
	always_comb begin
		O_IRQ[BIT_UNDER] = flag_q[BIT_UNDER] & irq_en_q[BIT_UNDER];
		O_IRQ[BIT_OVER] = flag_q[BIT_OVER] & irq_en_q[BIT_OVER];
		O_IRQ[BIT_D] = flag_q[BIT_D] & irq_en_q[BIT_D];
		O_IRQ[BIT_C] = flag_q[BIT_C] & irq_en_q[BIT_C];
		O_IRQ[BIT_B] = flag_q[BIT_B] & irq_en_q[BIT_B];
		O_IRQ[BIT_A] = flag_q[BIT_A] & irq_en_q[BIT_A];
	end

	// Converter start is a one-cycle pulse, registered so that bus
	// writes to the enable cannot glitch it.
	// A start therefore follows its cause by exactly one clock.
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_ADC_START <= 1'b0;
		end else begin
			O_ADC_START <= (I_FLAG_SET[BIT_A] & irq_en_q[BIT_ADC_TRIG])
				| (I_TROUGH_UNDERFLOW & irq_en_q[BIT_TROUGH]);
		end
	end

	// ==========================================================
	// Pin synchronisers; only the second stage and beyond feed logic.
	// The third stage only remembers the previous sample for the edge
	// detectors; it is never read without the second.
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			pin_s1_q <= 4'h0;
			pin_s2_q <= 4'h0;
			pin_s3_q <= 4'h0;
			c5_s1_q <= 3'h0;
			c5_s2_q <= 3'h0;
			c5_s3_q <= 3'h0;
		end else begin
			pin_s1_q <= I_PIN_IN;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			c5_s1_q <= I_CH5_PIN;
			c5_s2_q <= c5_s1_q;
			c5_s3_q <= c5_s2_q;
		end
	end

	// ==========================================================
	// Synchroniser warm-up. The pipelines reset to zero while a pin may
	// idle high, so the first samples after reset would look like a
	// rising edge. A capture code written at the earliest legal moment
	// would then record an event that never happened on the pin. Edge
	// detection is held off until the third stage holds a real sample;
	// the cost is that an edge in the first cycles after reset is lost.
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			warm_cnt_q <= 2'h0;
		end else if (warm_cnt_q != SYNC_WARM) begin
			warm_cnt_q <= warm_cnt_q + 2'h1;
		end
	end

	assign sync_ready = (warm_cnt_q == SYNC_WARM);

	// ==========================================================
	// Channel 3/4 A and C pins. Index 1 and 3 are C registers, which
	// hold their pin level and never capture while buffering the A register; the driver enable still follows the code.
	// A compare code loads its start level at the write itself, so the
	// pin shows the right level before the first match; the two hold
	// codes leave the level alone, which is why 0100 does not load.
	assign io4_ignored = {buf_a_en_q[1], 1'b0, buf_a_en_q[0], 1'b0};

	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			pin_out_q <= 4'h0;
			capture_q <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				capture_q[i] <= 1'b0;
				if (wr && PADDR == OFS_CH3_IO_HIGH + 8'(4 * i)) begin
					// Writing an output code loads its initial level.
					if (!PWDATA[3] && PWDATA[1:0] != 2'h0
						&& !io4_ignored[i]) begin
						pin_out_q[i] <= PWDATA[2];
					end
				end else if (io4_ignored[i]) begin
					pin_out_q[i] <= pin_out_q[i];
				end else if (!io4_q[i][3]) begin
					if (I_CMP_MATCH[i]) begin
						case (io4_q[i][1:0])
							2'h1: pin_out_q[i] <= 1'b0;
							2'h2: pin_out_q[i] <= 1'b1;
							2'h3: pin_out_q[i] <= ~pin_out_q[i];
							default: pin_out_q[i] <= pin_out_q[i];
						endcase
					end
				end else begin
					capture_q[i] <= sync_ready
						& edge_hit(io4_q[i][1:0],
						pin_s2_q[i], pin_s3_q[i]);
				end
			end
		end
	end

	assign O_PIN_OUT = pin_out_q;

	// The driver follows the code alone, so a pin is driven from reset on
	// and released the moment an input code is written.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			O_PIN_OE[i] = ~io4_q[i][3];
		end
	end

	assign O_CAPTURE = capture_q;

	// ==========================================================
	// Channel 5 units: compare, edge capture and pulse-width measurement.
	// The counter core counts while the count enable stands and takes the
	// capture at trough or crest; prohibited codes produce no events.
	// A unit counter is cleared only through its own enable bit; the bits
	// run U, V, W from bit 2 down, hence the reversed index.
	always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			c5_capture_q <= 3'h0;
			c5_clear_q <= 3'h0;
			c5_count_en_q <= 3'h0;
		end else begin
			for (int u = 0; u < 3; u++) begin
				logic ev;
				logic cap;
				ev = 1'b0;
				cap = 1'b0;
				c5_count_en_q[u] <= 1'b0;
				case (c5_mode(io5_q[u]))
					C5M_COMPARE: ev = I_CH5_MATCH[u];
					C5M_CAPTURE: begin
						cap = sync_ready
							& edge_hit(io5_q[u][1:0] - 2'h1,
							c5_s2_q[u], c5_s3_q[u]);
						ev = cap;
					end
					C5M_LOW_WIDTH, C5M_HIGH_WIDTH: begin
						c5_count_en_q[u] <= (c5_s2_q[u]
							== io5_q[u][2]);
						cap = (io5_q[u][0] & I_CH5_TROUGH[u])
							| (io5_q[u][1] & I_CH5_CREST[u]);
						ev = cap;
					end
					default: ev = 1'b0;
				endcase
				c5_capture_q[u] <= cap;
				c5_clear_q[u] <= ev & clr_en_q[2 - u];
			end
		end
	end

	assign O_CH5_CAPTURE = c5_capture_q;
	assign O_CH5_CLEAR = c5_clear_q;
	assign O_CH5_COUNT_EN = c5_count_en_q;

endmodule

// ==== tic_props.sv ====
// Checker of the timer I/O block port behaviour.
module tic_props
	import tic_pkg::*;
#(
	parameter int IRQ_CHANNEL = 4
) (
	input wire logic              I_REF_CLK,
	input wire logic              I_RESETN,
	input wire logic              PSEL,
	input wire logic              PENABLE,
	input wire logic              PWRITE,
	input wire logic [7:0]        PADDR,
	input wire logic [31:0]       PRDATA,
	input wire logic              PREADY,
	input wire logic              PSLVERR,
	input wire logic [3:0]        I_CMP_MATCH,
	input wire logic [3:0]        O_PIN_OUT,
	input wire logic [FLAG_W-1:0] I_FLAG_SET,
	input wire logic              I_TROUGH_UNDERFLOW,
	input wire logic [FLAG_W-1:0] O_IRQ,
	input wire logic              O_ADC_START
);
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RESETN);

	// ==========================================================
	// Access phase decode shared by the properties below.
	wire rd_acc = PSEL && PENABLE && !PWRITE;
	wire wr_acc = PSEL && PENABLE && PWRITE;

	// ==========================================================
	// Bus answers.
	chk_ready_always: assert property (PREADY)
		else $error("bus stalled");
	chk_rdata_upper: assert property (
		rd_acc |-> PRDATA[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_clr_reserved: assert property (
		rd_acc && PADDR == OFS_CLEAR_EN |-> PRDATA[7:3] == 5'h0)
		else $error("clear register reserved bits set");
	chk_unmapped_err: assert property (
		PSEL && PENABLE && PADDR > OFS_MODE |-> PSLVERR)
		else $error("unmapped access not refused");

	// ==========================================================
	// Outputs tied to their causes.
	chk_under_masked: assert property (
		IRQ_CHANNEL inside {1, 2} || !O_IRQ[BIT_UNDER])
		else $error("underflow request in wrong channel");
	chk_adc_cause: assert property (
		O_ADC_START |-> $past(I_FLAG_SET[BIT_A])
			|| $past(I_TROUGH_UNDERFLOW))
		else $error("converter start without cause");
	chk_pin_cause: assert property (
		$changed(O_PIN_OUT[0]) |-> $past(I_CMP_MATCH[0])
			|| $past(wr_acc))
		else $error("pin moved without match or write");
	chk_irq_rise: assert property (
		$rose(O_IRQ[BIT_A]) |-> $past(I_FLAG_SET[BIT_A])
			|| $past(wr_acc))
		else $error("request rose without cause");

	// Main scenarios reached.
	cov_adc: cover property (O_ADC_START);
	cov_irq: cover property (O_IRQ[BIT_A]);
	cov_err: cover property (PSLVERR);
endmodule

bind tic_timer_io_ctrl tic_props #(.IRQ_CHANNEL(IRQ_CHANNEL)) i_props (
	.I_REF_CLK(I_REF_CLK), .I_RESETN(I_RESETN), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .I_CMP_MATCH(I_CMP_MATCH),
	.O_PIN_OUT(O_PIN_OUT), .I_FLAG_SET(I_FLAG_SET), .O_IRQ(O_IRQ),
	.I_TROUGH_UNDERFLOW(I_TROUGH_UNDERFLOW), .O_ADC_START(O_ADC_START));

// ==== tic_pin_model.sv ====
// Far side of the timer pins: resolves each two-way pin level.
module tic_pin_model (
	input  wire logic [3:0] i_drive,
	input  wire logic [3:0] i_out,
	input  wire logic [3:0] i_oe,
	output logic      [3:0] o_pin
);
	// The block wins while it drives; the outside drives a released pin.
	assign o_pin = (i_oe & i_out) | (~i_oe & i_drive);
endmodule

// ==== tic_timer_io_ctrl_tb.sv ====
// Self-checking bench of the timer I/O block.
module tic_timer_io_ctrl_tb import tic_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0;
	logic        pwr = 1'b0, tro = 1'b0, pready, pslverr, adc, er;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic [3:0]  cm = 4'h0, drv = 4'h0, pin, pout, poe, cap;
	logic [5:0]  fs = 6'h00, irq;
	logic [2:0]  c5m = 3'h0, d5 = 3'h7, c5cap, c5en, c5clr;
	logic [2:0]  c5t = 3'h0, c5c = 3'h0;
	logic [3:0]  oc [6] = '{4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h5};
	logic [3:0]  cc [3] = '{4'h8, 4'h9, 4'hE};
	int          fails = 0, cmp_count = 0, ncap = 0, n5 = 0, a0;

	// ==========================================================
	// Clock and capture pulse counters.
	always #20 clk = ~clk;
	always @(posedge clk) begin
		if (cap[0] === 1'b1) ncap <= ncap + 1;
		if (c5cap[0] === 1'b1) n5 <= n5 + 1;
	end

	tic_timer_io_ctrl #(.IRQ_CHANNEL(4)) i_tic_timer_io_ctrl (
		.I_REF_CLK(clk), .I_RESETN(rst_n), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .I_CMP_MATCH(cm),
		.I_PIN_IN(pin), .O_PIN_OUT(pout), .O_PIN_OE(poe), .O_CAPTURE(cap),
		.I_CH5_MATCH(c5m), .I_CH5_PIN(d5), .I_CH5_TROUGH(c5t),
		.I_CH5_CREST(c5c), .O_CH5_CAPTURE(c5cap), .O_CH5_COUNT_EN(c5en),
		.O_CH5_CLEAR(c5clr), .I_FLAG_SET(fs), .I_TROUGH_UNDERFLOW(tro),
		.O_IRQ(irq), .O_ADC_START(adc));
	tic_pin_model i_tic_pin_model (.i_drive(drv), .i_out(pout),
		.i_oe(poe), .o_pin(pin));

	// ==========================================================
	// Tasks. Each one that waits on the clock ends at a falling edge, so outputs have settled.
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(negedge clk);
	endtask
	task automatic ev(input logic [3:0] m, input logic [5:0] f,
			input logic [2:0] u, input logic t);
		@(posedge clk);
		cm <= m;
		fs <= f;
		c5m <= u;
		tro <= t;
		@(posedge clk);
		cm <= 4'h0;
		fs <= 6'h00;
		c5m <= 3'h0;
		tro <= 1'b0;
		@(negedge clk);
	endtask
	// One-cycle trough and crest pulses from the counter core.
	task automatic pw(input logic [2:0] t, input logic [2:0] c);
		@(posedge clk);
		c5t <= t;
		c5c <= c;
		@(posedge clk);
		c5t <= 3'h0;
		c5c <= 3'h0;
		@(negedge clk);
	endtask
	// Pins are slow: leave time for the synchroniser and edge detect.
	task automatic pv(input int which, input logic v);
		@(posedge clk);
		if (which == 0) drv[0] <= v;
		else d5[0] <= v;
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// A hang counts as a mismatch.
	initial begin
		repeat (4000) @(posedge clk);
		fails++;
		close_out();
	end

	// ==========================================================
	// Test sequence.
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk(32'(pout), 32'h0);
		chk(32'(poe), 32'hF);
		for (int a = 0; a <= 40; a += 4) begin
			apb(1'b0, 8'(a), 32'h0);
			chk(rv, 32'h0);
		end
		apb(1'b0, 8'h40, 32'h0);
		chk(32'(er), 32'h1);
		apb(1'b1, OFS_CLEAR_EN, 32'hFF);
		apb(1'b0, OFS_CLEAR_EN, 32'h0);
		chk(rv, 32'h7);
		apb(1'b1, OFS_IRQ_EN, 32'hFF);
		apb(1'b0, OFS_IRQ_EN, 32'h0);
		chk(rv, 32'hDF);
		$display("done registers");
		foreach (oc[i]) begin
			apb(1'b1, OFS_CH3_IO_HIGH, {28'h0, oc[i]});
			chk(32'(pout[0]), 32'(oc[i][2]));
			ev(4'h1, 6'h00, 3'h0, 1'b0);
			chk(32'(pout[0]),
				32'(oc[i][1] ? (oc[i][0] ? !oc[i][2] : 1'b1) : 1'b0));
		end
		apb(1'b1, OFS_CH3_IO_HIGH, 32'h4);
		ev(4'h1, 6'h00, 3'h0, 1'b0);
		chk(32'(pout[0]), 32'h0);
		foreach (cc[i]) begin
			apb(1'b1, OFS_CH3_IO_HIGH, {28'h0, cc[i]});
			a0 = ncap;
			pv(0, 1'b1);
			chk(32'(ncap - a0), 32'(cc[i][1] | !cc[i][0]));
			pv(0, 1'b0);
			chk(32'(ncap - a0), cc[i][1] ? 32'h2 : 32'h1);
		end
		apb(1'b1, OFS_MODE, 32'h1);
		apb(1'b1, OFS_CH3_IO_LOW, 32'h3);
		ev(4'h2, 6'h00, 3'h0, 1'b0);
		chk(32'(pout[1]), 32'h0);
		$display("done pins");
		apb(1'b1, OFS_CLEAR_EN, 32'h4);
		ev(4'h0, 6'h00, 3'h7, 1'b0);
		chk(32'(c5clr), 32'h1);
		apb(1'b1, OFS_CH5U_IO, 32'h11);
		a0 = n5;
		pv(1, 1'b0);
		pv(1, 1'b1);
		chk(32'(n5 - a0), 32'h1);
		apb(1'b1, OFS_CH5U_IO, 32'h19);
		pv(1, 1'b0);
		chk(32'(c5en[0]), 32'h1);
		pw(3'h1, 3'h0);
		chk(32'(c5cap), 32'h1);
		pw(3'h0, 3'h1);
		chk(32'(c5cap), 32'h0);
		apb(1'b1, OFS_CH5U_IO, 32'h1D);
		pv(1, 1'b0);
		chk(32'(c5en[0]), 32'h0);
		pw(3'h1, 3'h0);
		chk(32'(c5cap), 32'h1);
		$display("done channel 5");
		ev(4'h0, 6'h3F, 3'h0, 1'b1);
		chk(32'(irq), 32'h1F);
		chk(32'(adc), 32'h1);
		apb(1'b1, OFS_IRQ_EN, 32'h40);
		chk(32'(irq), 32'h0);
		ev(4'h0, 6'h01, 3'h0, 1'b0);
		chk(32'(adc), 32'h0);
		ev(4'h0, 6'h00, 3'h0, 1'b1);
		chk(32'(adc), 32'h1);
		apb(1'b1, OFS_IRQ_EN, 32'h80);
		ev(4'h0, 6'h00, 3'h0, 1'b1);
		chk(32'(adc), 32'h0);
		apb(1'b1, OFS_IRQ_EN, 32'h13);
		chk(32'(irq), 32'h13);
		apb(1'b1, OFS_STATUS, 32'h0);
		chk(32'(irq), 32'h13);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rv, 32'h1F);
		apb(1'b1, OFS_STATUS, 32'h3E);
		chk(32'(irq), 32'h12);
		$display("done interrupts");
		close_out();
	end
endmodule
